// ==== core/blc_threshold_ctrl.sv ====
// Black level threshold and calibration control registers and limits
//
// Overview of operation
// (R01) No-gain-dependence set: lower limit programmed, upper reloaded from field on restart.
// (R02) No-gain-dependence and override clear: both limits derived automatically.
// (R03) Upper limit is a seven-bit field, default lower limit plus five.
// (R04) Override set: upper limit equals programmed seven-bit field.
// (R05) No-gain set, override clear: upper reloaded from field after every restart unless control bit 11 is set.
// (R06) Override fixes both limits to fields; clear means automatic adjustment.
// (R07) Lower threshold held in six-bit field at bottom of threshold register.
// (R08) Automatic lower limit: max gain/4 times (bit6+1) times (bit7+1).
// (R09) Gain operand is the maximum of the four colour gains.
// (R10) Jump, new level under 64: upper = lower + 2 + twice excess.
// (R11) Jump, new level 64 to 118: upper = new level plus four.
// (R12) Jump, new level above middle range: upper clamped to 123.
// (R13) After restart upper resets to lower+5 auto, or field on override.
// (R14) Control bit 11 suppresses the post-restart upper limit reset.
// (R15) Control bit 15 skips the rapid sweep after new gain settings.
// (R16) Software keeps reserved control bits 14 and 10..3 at zero.
// (R17) Writing control bit 12 restarts average and sweep; bit self-clears.
// (R18) Register values sampled at each evaluation start; writes apply next evaluation. Code reads control bit 15 unsampled.
`timescale 1ns/100ps
module blc_threshold_ctrl
	import blc_pkg::*;
#(
	parameter int NUM_GAINS = 4
)
(
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   sys_rst,
	// Register port (sensor register file side)
	input  wire blc_wr_t                reg_wr,
	input  wire logic [7:0]             reg_rd_addr,
	output logic      [15:0]            reg_rd_data,
	// Gain settings
	input  wire logic [NUM_GAINS*8-1:0] gain_settings,
	input  wire logic                   gain_update,
	// Calibration filter events
	input  wire logic                   eval_start,
	input  wire logic                   recalc_done,
	input  wire blc_jump_t              cal_jump,
	// Outputs to the calibration loop
	output logic      [5:0]             lower_black_limit,
	output logic      [6:0]             upper_black_limit,
	output logic                        avg_restart,
	output logic                        sweep_start
);
	logic [15:0] thresh_q;
	logic [15:0] ctrl_q;
	logic [15:0] thresh_s_q;
	logic [15:0] ctrl_s_q;
	logic [7:0]  largest_gain_setting;
	logic [5:0]  auto_lo;
	logic [5:0]  lo_d;
	logic [6:0]  hi_d;
	logic [6:0]  hi_q;
	logic        restart_req_q;
	logic        ovr;
	logic        nogain;
	logic [6:0]  field_hi;
	logic [5:0]  field_lo;
	logic [6:0]  lo7;
	logic [6:0]  excess;
	logic [7:0]  low_jump_sum;

	// Largest gain and automatic lower limit
	blc_gain_max #(
		.NUM_GAINS            (NUM_GAINS)
	) u_gain_max (
		.sys_clk              (sys_clk),
		.sys_rst              (sys_rst),
		.gain_settings        (gain_settings),
		.largest_gain_setting (largest_gain_setting),
		.auto_lower_limit     (auto_lo)
	);

	// Threshold register, fully writable
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			thresh_q <= BLC_THRESH_RESET;
		else if (reg_wr.en && reg_wr.addr == BLC_ADDR_THRESH)
			thresh_q <= reg_wr.data; // (R03) (R07)
	end

	// Control register; reserved bits forced to zero, restart bit never stored
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			ctrl_q <= BLC_CTRL_RESET;
		else if (reg_wr.en && reg_wr.addr == BLC_ADDR_CTRL)
			ctrl_q <= reg_wr.data & BLC_CTRL_WMASK & ~(16'h0001 << BLC_RESTART_BIT); // (R16) (R17)
	end

	// Restart request held until the next evaluation start
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			restart_req_q <= 1'b0;
		else if (reg_wr.en && reg_wr.addr == BLC_ADDR_CTRL && reg_wr.data[BLC_RESTART_BIT])
			restart_req_q <= 1'b1; // (R17)
		else if (eval_start)
			restart_req_q <= 1'b0;
	end

	// Snapshot of both registers taken at evaluation start
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			thresh_s_q <= BLC_THRESH_RESET;
			ctrl_s_q   <= BLC_CTRL_RESET;
		end
		else if (eval_start)
		begin
			thresh_s_q <= thresh_q; // (R18)
			ctrl_s_q   <= ctrl_q; // (R18)
		end
	end

	// Readback; bit 12 always reads zero since it self-clears
	always_comb
	begin
		unique case (reg_rd_addr)
			BLC_ADDR_THRESH: reg_rd_data = thresh_q;
			BLC_ADDR_CTRL:   reg_rd_data = ctrl_q; // (R17)
			default:         reg_rd_data = 16'h0000;
		endcase
	end

	assign ovr      = thresh_s_q[BLC_OVR_BIT];
	assign nogain   = thresh_s_q[BLC_NOGAIN_BIT];
	assign field_hi = thresh_s_q[BLC_HI_MSB:BLC_HI_LSB];
	assign field_lo = thresh_s_q[BLC_LO_MSB:BLC_LO_LSB];

	// Lower limit source: field when override or no-gain, else automatic
	always_comb
	begin
		if (ovr || nogain)
			lo_d = field_lo; // (R01) (R06)
		else
			lo_d = auto_lo; // (R02) (R08)
	end

	assign lo7          = {1'b0, lower_black_limit};
	assign excess       = cal_jump.level - lo7;
	assign low_jump_sum = {1'b0, lo7} + {1'b0, BLC_JUMP_LOW_ADD} + {excess, 1'b0};

	// Upper limit next value; override wins, then restart, then jump
	always_comb
	begin
		hi_d = hi_q;
		if (ovr)
			hi_d = field_hi; // (R04) (R06)
		else if (avg_restart && !ctrl_s_q[BLC_NOHIRST_BIT])
		begin
			if (nogain)
				hi_d = field_hi; // (R01) (R05)
			else
				hi_d = lo7 + BLC_HI_MARGIN; // (R13) (R03)
		end
		else if (cal_jump.jump)
		begin
			if (cal_jump.level < BLC_JUMP_LOW_LIM)
				hi_d = (low_jump_sum > {1'b0, BLC_HI_MAX}) ? BLC_HI_MAX
					: low_jump_sum[6:0]; // (R10)
			else if (cal_jump.level < BLC_JUMP_MID_LIM)
				hi_d = cal_jump.level + BLC_JUMP_MID_ADD; // (R11)
			else
				hi_d = BLC_HI_CLAMP; // (R12)
		end
	end

	// Limits
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			lower_black_limit <= BLC_LO_RESET;
			hi_q              <= {1'b0, BLC_LO_RESET} + BLC_HI_MARGIN; // (R03)
		end
		else
		begin
			lower_black_limit <= lo_d;
			hi_q              <= hi_d; // (R14)
		end
	end
	assign upper_black_limit = hi_q;

	// Restart pulse: software request at evaluation start, or filter recalculation
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			avg_restart <= 1'b0;
		else
			avg_restart <= (eval_start && restart_req_q) || recalc_done; // (R17)
	end

	// Sweep: forced by software restart request (not recalculation), gain-triggered unless bit 15 set
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			sweep_start <= 1'b0;
		else
			sweep_start <= (eval_start && restart_req_q)
				|| (gain_update && !ctrl_q[BLC_NOSWEEP_BIT]); // (R15) (R17)
	end

	// Assertions
	chk_ovr_hi: assert property (@(posedge sys_clk) disable iff (sys_rst) // (R04)
		ovr |=> upper_black_limit == $past(field_hi))
		else $error("override upper limit mismatch");
	chk_lo_field: assert property (@(posedge sys_clk) disable iff (sys_rst) // (R06)
		(ovr || nogain) |=> lower_black_limit == $past(field_lo))
		else $error("lower limit not from field");
	chk_lo_auto: assert property (@(posedge sys_clk) disable iff (sys_rst) // (R02)
		!(ovr || nogain) |=> lower_black_limit == $past(auto_lo))
		else $error("lower limit not automatic");
	chk_restart_hi: assert property (@(posedge sys_clk) disable iff (sys_rst) // (R13)
		(avg_restart && !ovr && !nogain && !ctrl_s_q[BLC_NOHIRST_BIT])
		|=> upper_black_limit == $past(lo7) + BLC_HI_MARGIN)
		else $error("upper limit not reset to lower plus five");
	chk_nogain_hi: assert property (@(posedge sys_clk) disable iff (sys_rst) // (R05)
		(avg_restart && !ovr && nogain && !ctrl_s_q[BLC_NOHIRST_BIT])
		|=> upper_black_limit == $past(field_hi))
		else $error("upper limit not reloaded from field");
	chk_hold_hi: assert property (@(posedge sys_clk) disable iff (sys_rst) // (R14)
		(avg_restart && !ovr && ctrl_s_q[BLC_NOHIRST_BIT] && !cal_jump.jump)
		|=> $stable(upper_black_limit))
		else $error("upper limit reset despite suppression");
	chk_jump_mid: assert property (@(posedge sys_clk) disable iff (sys_rst) // (R11)
		(cal_jump.jump && !ovr && !avg_restart && cal_jump.level >= BLC_JUMP_LOW_LIM
		&& cal_jump.level < BLC_JUMP_MID_LIM)
		|=> upper_black_limit == $past(cal_jump.level) + BLC_JUMP_MID_ADD)
		else $error("mid range jump limit wrong");
	chk_jump_clamp: assert property (@(posedge sys_clk) disable iff (sys_rst) // (R12)
		(cal_jump.jump && !ovr && !avg_restart && cal_jump.level >= BLC_JUMP_MID_LIM)
		|=> upper_black_limit == BLC_HI_CLAMP)
		else $error("high jump not clamped");
	chk_no_sweep: assert property (@(posedge sys_clk) disable iff (sys_rst) // (R15)
		(gain_update && ctrl_q[BLC_NOSWEEP_BIT] && !(eval_start && restart_req_q))
		|=> !sweep_start)
		else $error("sweep despite disable bit");
	chk_restart_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst) // (R17)
		(eval_start && restart_req_q) |=> avg_restart && sweep_start ##1 !restart_req_q)
		else $error("restart request not serviced");
	chk_ctrl_clear: assert property (@(posedge sys_clk) disable iff (sys_rst) // (R17)
		!ctrl_q[BLC_RESTART_BIT])
		else $error("restart bit stored");

	// Low jump: lower + 2 + twice the excess, worked out in int so no wrap hides
	chk_jump_low: assert property (@(posedge sys_clk) disable iff (sys_rst) // (R10)
		(cal_jump.jump && !ovr && !avg_restart && cal_jump.level < BLC_JUMP_LOW_LIM
		&& cal_jump.level >= lo7)
		|=> int'(upper_black_limit)
		== ((2 * int'($past(cal_jump.level)) + 2 - int'($past(lo7)) > 127) ? 127
		: 2 * int'($past(cal_jump.level)) + 2 - int'($past(lo7))))
		else $error("low range jump limit wrong");

	// Snapshot only moves at an evaluation start
	chk_snap_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // (R18)
		!eval_start |=> $stable(thresh_s_q) && $stable(ctrl_s_q))
		else $error("register snapshot moved outside evaluation");

	// New gains start a sweep while bit 15 is clear
	chk_gain_sweep: assert property (@(posedge sys_clk) disable iff (sys_rst) // (R15)
		(gain_update && !ctrl_q[BLC_NOSWEEP_BIT]) |=> sweep_start)
		else $error("no sweep after new gains");

	// Reserved control bits never read back as one
	chk_rd_reserved: assert property (@(posedge sys_clk) disable iff (sys_rst) // (R16)
		(reg_rd_addr == BLC_ADDR_CTRL) |-> (reg_rd_data & ~BLC_CTRL_WMASK) == 16'h0000)
		else $error("reserved control bit reads one");

	// A finished recalculation always restarts the average
	chk_recalc_restart: assert property (@(posedge sys_clk) disable iff (sys_rst) // (R13)
		recalc_done |=> avg_restart)
		else $error("recalculation without average restart");

	// Largest gain is never below any colour gain of the cycle before
	for (genvar g = 0; g < NUM_GAINS; g++)
	begin : gen_gain_chk
		chk_gain_max: assert property (@(posedge sys_clk) disable iff (sys_rst) // (R09)
			1'b1 |=> largest_gain_setting >= $past(gain_settings[g*8 +: 8]))
			else $error("largest gain below a colour gain");
	end

	// Main scenarios: low jump, software restart, programmed modes, sweeps, held limit
	cov_jump_low: cover property (@(posedge sys_clk) disable iff (sys_rst)
		cal_jump.jump && !ovr && cal_jump.level < BLC_JUMP_LOW_LIM);
	cov_restart: cover property (@(posedge sys_clk) disable iff (sys_rst)
		eval_start && restart_req_q);
	cov_ovr: cover property (@(posedge sys_clk) disable iff (sys_rst) ovr && nogain);
	cov_gain_sweep: cover property (@(posedge sys_clk) disable iff (sys_rst) sweep_start);
	cov_hold_hi: cover property (@(posedge sys_clk) disable iff (sys_rst)
		avg_restart && ctrl_s_q[BLC_NOHIRST_BIT]);
endmodule

// ==== shared/blc_pkg.sv ====
// Package for the black level threshold control block
package blc_pkg;
	// Register addresses (8-bit sensor register space)
	localparam logic [7:0]  BLC_ADDR_THRESH   = 8'h5f;
	localparam logic [7:0]  BLC_ADDR_CTRL     = 8'h62;
	// Threshold register fields
	localparam int          BLC_NOGAIN_BIT    = 15;
	localparam int          BLC_HI_MSB        = 14;
	localparam int          BLC_HI_LSB        = 8;
	localparam int          BLC_OVR_BIT       = 7;
	localparam int          BLC_LO_MSB        = 5;
	localparam int          BLC_LO_LSB        = 0;
	// Control register fields
	localparam int          BLC_NOSWEEP_BIT   = 15;
	localparam int          BLC_RESTART_BIT   = 12;
	localparam int          BLC_NOHIRST_BIT   = 11;
	localparam logic [15:0] BLC_CTRL_WMASK    = 16'h9807;
	// Reset values and limit arithmetic
	localparam logic [5:0]  BLC_LO_RESET      = 6'h00_04;
	localparam logic [6:0]  BLC_HI_MARGIN     = 7'h05;
	localparam logic [15:0] BLC_THRESH_RESET  = 16'h0904;
	localparam logic [15:0] BLC_CTRL_RESET    = 16'h0000;
	localparam logic [6:0]  BLC_JUMP_LOW_LIM  = 7'h40;
	localparam logic [6:0]  BLC_JUMP_MID_LIM  = 7'h77;
	localparam logic [6:0]  BLC_JUMP_LOW_ADD  = 7'h02;
	localparam logic [6:0]  BLC_JUMP_MID_ADD  = 7'h04;
	localparam logic [6:0]  BLC_HI_CLAMP      = 7'h7b;
	localparam logic [6:0]  BLC_HI_MAX        = 7'h7f;

	// Register write request
	typedef struct packed {
		logic        en;
		logic [7:0]  addr;
		logic [15:0] data;
	} blc_wr_t;

	// Calibration event from the filter
	typedef struct packed {
		logic        jump;
		logic [6:0]  level;
	} blc_jump_t;
endpackage

// ==== core/blc_gain_max.sv ====
// Largest-gain selector and automatic lower limit
`timescale 1ns/100ps
module blc_gain_max
	import blc_pkg::*;
#(
	parameter int NUM_GAINS = 4
)
(
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   sys_rst,
	// Gain settings
	input  wire logic [NUM_GAINS*8-1:0] gain_settings,
	// Results
	output logic      [7:0]             largest_gain_setting,
	output logic      [5:0]             auto_lower_limit
);
	logic [7:0] max_c;
	logic [9:0] prod_c;

	// Maximum over all colour gains
	always_comb
	begin
		max_c = gain_settings[7:0];
		for (int i = 1; i < NUM_GAINS; i++)
			if (gain_settings[i*8 +: 8] > max_c)
				max_c = gain_settings[i*8 +: 8];
	end

	// Gain/4 scaled by (bit6+1)*(bit7+1); saturate to the 6-bit field
	always_comb
	begin
		prod_c = {4'h0, max_c[5:0]} >> 2;
		if (max_c[6])
			prod_c = prod_c << 1;
		if (max_c[7])
			prod_c = prod_c << 1;
	end

	// Registered to keep the comparator tree off the limit path
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			largest_gain_setting <= 8'h00;
			auto_lower_limit     <= BLC_LO_RESET;
		end
		else
		begin
			largest_gain_setting <= max_c; // (R09)
			auto_lower_limit     <= (prod_c > 10'h03f) ? 6'h3f : prod_c[5:0]; // (R08)
		end
	end
endmodule

// ==== test/blc_threshold_ctrl_test.sv ====
// Self-checking bench for the black level threshold control block
`timescale 1ns/100ps
module blc_threshold_ctrl_test import blc_pkg::*;;
	// Design ports
	logic        sys_clk = 1'b0;
	logic        sys_rst;
	blc_wr_t     reg_wr;
	logic [7:0]  reg_rd_addr;
	logic [15:0] reg_rd_data;
	logic [31:0] gain_settings;
	logic        gain_update;
	logic        eval_start;
	logic        recalc_done;
	blc_jump_t   cal_jump;
	logic [5:0]  lower;
	logic [6:0]  upper;
	logic        avg_restart;
	logic        sweep_start;
	// Bench state
	int          bad_count = 0;
	int          n_checks = 0;
	logic [6:0]  h;
	logic [5:0]  l;
	logic [5:0]  plo = 6'h08;
	// Jump levels around each range boundary
	logic [6:0]  lv [6] = '{7'h0f, 7'h3f, 7'h40, 7'h76, 7'h77, 7'h7f};

	blc_threshold_ctrl #(.NUM_GAINS(4)) blc_threshold_ctrl_i (
		.sys_clk           (sys_clk),
		.sys_rst           (sys_rst),
		.reg_wr            (reg_wr),
		.reg_rd_addr       (reg_rd_addr),
		.reg_rd_data       (reg_rd_data),
		.gain_settings     (gain_settings),
		.gain_update       (gain_update),
		.eval_start        (eval_start),
		.recalc_done       (recalc_done),
		.cal_jump          (cal_jump),
		.lower_black_limit (lower),
		.upper_black_limit (upper),
		.avg_restart       (avg_restart),
		.sweep_start       (sweep_start)
	);

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Ends on a settled point just after an edge
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= '{1'b1, a, d};
		@(posedge sys_clk);
		reg_wr.en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		reg_rd_addr <= a;
		tick(1);
		chk("reg_rd_data", exp, reg_rd_data);
	endtask

	// One-cycle strobe: 0 evaluation, 1 recalculation, 2 gain update
	task automatic pulse(input int k);
		@(posedge sys_clk);
		{gain_update, recalc_done, eval_start} <= 3'(1 << k);
		@(posedge sys_clk);
		{gain_update, recalc_done, eval_start} <= 3'b000;
	endtask

	// Pulses are short, so both are watched over a small window
	task automatic watch(input logic ea, input logic es);
		logic [1:0] seen;
		seen = 2'b00;
		repeat (4)
		begin
			#1;
			seen = seen | {avg_restart, sweep_start};
			@(posedge sys_clk);
		end
		chk("restart_sweep", 16'({ea, es}), 16'(seen));
	endtask

	task automatic jump(input logic [6:0] lvl);
		@(posedge sys_clk);
		cal_jump <= '{1'b1, lvl};
		@(posedge sys_clk);
		cal_jump.jump <= 1'b0;
		tick(2);
	endtask

	task automatic lim(input logic [5:0] el, input logic [6:0] eh);
		chk("lower_black_limit", 16'(el), 16'(lower));
		chk("upper_black_limit", 16'(eh), 16'(upper));
	endtask

	// Largest gain over four, scaled by its two top bits
	function automatic logic [5:0] auto_lo(input logic [31:0] g);
		logic [7:0] m;
		logic [5:0] v;
		m = 8'h00;
		for (int i = 0; i < 4; i++)
			if (g[8*i +: 8] > m)
				m = g[8*i +: 8];
		v = m[5:0] >> 2;
		v = v << m[6];
		v = v << m[7];
		return v;
	endfunction

	function automatic logic [6:0] jump_hi(input logic [6:0] lvl, input logic [5:0] lo);
		int t;
		if (lvl < 64)
			t = int'(lo) + 2 + 2 * (int'(lvl) - int'(lo));
		else if (lvl < 119)
			t = int'(lvl) + 4;
		else
			t = 123;
		return 7'((t > 127) ? 127 : t);
	endfunction

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// A hang counts as a mismatch
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		print_verdict;
	end

	initial
	begin
		sys_rst = 1'b1;
		reg_wr = '0;
		reg_rd_addr = 8'h00;
		gain_settings = 32'h0000_0000;
		{gain_update, recalc_done, eval_start} = 3'b000;
		cal_jump = '0;
		void'($urandom(32'h4c5f));
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		// Reset values, an unmapped address, control bit masking
		rd(BLC_ADDR_THRESH, 16'h0904);
		rd(BLC_ADDR_CTRL, 16'h0000);
		rd(8'h00, 16'h0000);
		lim(auto_lo(32'h0000_0000), 7'h09);
		wr(BLC_ADDR_CTRL, 16'hffff);
		rd(BLC_ADDR_CTRL, BLC_CTRL_WMASK & 16'hefff);
		wr(BLC_ADDR_CTRL, 16'h0000);
		// Automatic limits from random gains, corners first
		for (int i = 0; i < 8; i++)
		begin
			@(posedge sys_clk);
			gain_settings <= (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_7f00 : $urandom;
			tick(3);
			pulse(0);
			pulse(1);
			tick(4);
			lim(auto_lo(gain_settings), 7'(auto_lo(gain_settings)) + 7'h05);
		end
		// Jump adjustment, upper limit reset before each
		@(posedge sys_clk);
		gain_settings <= 32'h2020_2020;
		tick(3);
		pulse(0);
		foreach (lv[i])
		begin
			pulse(1);
			tick(4);
			chk("upper_black_limit", 16'h000d, 16'(upper));
			jump(lv[i]);
			chk("upper_black_limit", 16'(jump_hi(lv[i], 6'h08)), 16'(upper));
		end
		// Upper limit kept over a recalculation
		wr(BLC_ADDR_CTRL, 16'h0800);
		pulse(0);
		jump(7'h40);
		pulse(1);
		tick(4);
		chk("upper_black_limit", 16'h0044, 16'(upper));
		// Restart request waits for the next evaluation
		wr(BLC_ADDR_CTRL, 16'h1000);
		rd(BLC_ADDR_CTRL, 16'h0000);
		watch(1'b0, 1'b0);
		pulse(0);
		watch(1'b1, 1'b1);
		// Sweep on new gains unless disabled
		pulse(2);
		watch(1'b0, 1'b1);
		wr(BLC_ADDR_CTRL, 16'h8000);
		pulse(2);
		watch(1'b0, 1'b0);
		// Programmed limits, override and no-gain modes
		for (int i = 0; i < 4; i++)
		begin
			h = 7'($urandom_range(127));
			l = 6'($urandom_range(63));
			wr(BLC_ADDR_THRESH, {i[0], h, ~i[0], 1'b0, l});
			rd(BLC_ADDR_THRESH, {i[0], h, ~i[0], 1'b0, l});
			chk("lower_black_limit", 16'(plo), 16'(lower));
			pulse(0);
			pulse(1);
			tick(4);
			lim(l, h);
			plo = l;
		end
		print_verdict;
	end
endmodule
